// ---- logic/acc_pkg.sv ----
/*
  Constants, register map and carrier types for the two-channel analog
  comparator control block.
  Assumes an 8-bit special function register bus on the system clock.
*/
`default_nettype none
package acc_pkg;
  // register addresses, index 0 and 1 are the two channels
  localparam logic [7:0] ACC_CN_ADDR [0:1] = '{8'h9A, 8'h9D};
  localparam logic [7:0] ACC_MD_ADDR [0:1] = '{8'h9B, 8'h9E};
  localparam logic [7:0] ACC_MX_ADDR [0:1] = '{8'h9C, 8'h9F};

  // control register fields
  localparam int ACC_CN_EN_BIT = 7;
  localparam int ACC_CN_OUT_BIT = 6;
  localparam int ACC_CN_RISE_BIT = 5;
  localparam int ACC_CN_FALL_BIT = 4;
  localparam int ACC_CN_HYP_LSB = 2;
  localparam int ACC_CN_HYN_LSB = 0;
  // mode register fields
  localparam int ACC_MD_RIE_BIT = 5;
  localparam int ACC_MD_FIE_BIT = 4;
  localparam int ACC_MD_MODE_LSB = 0;
  // input select register fields
  localparam int ACC_MX_PLUS_LSB = 0;
  localparam int ACC_MX_MINUS_LSB = 4;

  // values after reset, and the code that selects 20 mV hysteresis
  localparam logic [1:0] ACC_MODE_RST = 2'h2;
  localparam logic [1:0] ACC_FIELD2_RST = 2'h0;
  localparam logic [7:0] ACC_BYTE_RST = 8'h00;
  localparam logic [1:0] ACC_HYST_20MV_CODE = 2'h3;

  // one-hot hysteresis selection toward the analog core
  localparam logic [3:0] ACC_HYST_OFF = 4'h1;
  localparam logic [3:0] ACC_HYST_5MV = 4'h2;
  localparam logic [3:0] ACC_HYST_10MV = 4'h4;
  localparam logic [3:0] ACC_HYST_20MV = 4'h8;

  typedef struct packed {
    logic en;
    logic [1:0] pos_hyst;
    logic [1:0] neg_hyst;
    logic rise_ie;
    logic fall_ie;
    logic [1:0] mode;
    logic [1:0] plus_sel;
    logic [1:0] minus_sel;
  } acc_cfg_t;

  typedef struct packed {
    logic result;
    logic rise_flag;
    logic fall_flag;
    logic irq;
  } acc_stat_t;

  typedef struct packed {
    logic power;
    logic [1:0] mode;
    logic [1:0] plus_sel;
    logic [1:0] minus_sel;
    logic [3:0] pos_hyst;
    logic [3:0] neg_hyst;
  } acc_ana_t;

  // has_20mv is low for the channel-zero positive field, whose top code stays at 10 mV
  function automatic logic [3:0] acc_decode_hyst(input logic [1:0] code, input logic has_20mv);
    logic [3:0] sel;
    sel = ACC_HYST_OFF;
    unique case (code)
      2'h0: sel = ACC_HYST_OFF;
      2'h1: sel = ACC_HYST_5MV;
      2'h2: sel = ACC_HYST_10MV;
      2'h3: sel = has_20mv ? ACC_HYST_20MV : ACC_HYST_10MV;
    endcase
    return sel;
  endfunction : acc_decode_hyst
endpackage : acc_pkg
`default_nettype wire

// ---- logic/acc_chan.sv ----
/*
  One comparator channel: synchroniser, latched result, sticky edge flags
  and the interrupt request.
  Assumes cmp_raw_i is asynchronous to clk_sys_i; configuration inputs come
  from registers on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module acc_chan (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // analog comparator result
  input wire logic cmp_raw_i,
  // configuration
  input wire logic en_i,
  input wire logic rise_ie_i,
  input wire logic fall_ie_i,
  // software write of the flag bits
  input wire logic flag_wr_i,
  input wire logic rise_wdata_i,
  input wire logic fall_wdata_i,
  // status
  output acc_pkg::acc_stat_t stat_o
);
  logic sync_q1;
  logic sync_q2;
  logic result_q;
  logic prev_q;
  logic rise_q;
  logic fall_q;
  logic irq_q;
  logic next_sync1;
  logic next_sync2;
  logic next_result;
  logic next_prev;
  logic next_rise;
  logic next_fall;
  logic next_irq;
  logic rise_evt;
  logic fall_evt;

  always_comb
  begin
    next_sync1 = cmp_raw_i;
    next_sync2 = sync_q1;
    // disabled channel reads and drives low
    next_result = en_i & sync_q2;
    next_prev = result_q;
    rise_evt = en_i & result_q & ~prev_q;
    fall_evt = en_i & ~result_q & prev_q;
    // a hardware edge wins over a software clear in the same cycle
    next_rise = (flag_wr_i ? rise_wdata_i : rise_q) | rise_evt;
    next_fall = (flag_wr_i ? fall_wdata_i : fall_q) | fall_evt;
    next_irq = (next_rise & rise_ie_i) | (next_fall & fall_ie_i);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync_q1 <= 1'b0;
      sync_q2 <= 1'b0;
      result_q <= 1'b0;
      prev_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      sync_q1 <= next_sync1;
      sync_q2 <= next_sync2;
      result_q <= next_result;
      prev_q <= next_prev;
      rise_q <= next_rise;
      fall_q <= next_fall;
      irq_q <= next_irq;
    end
  end

  // one driver for the whole carrier: result, rise flag, fall flag, irq
  assign stat_o = {result_q, rise_q, fall_q, irq_q};

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  a_rise_sets_flag:
    assert property (en_i && result_q && !prev_q |=> rise_q)
    else $error("rising edge did not set the rise flag");
  a_fall_sets_flag:
    assert property (en_i && !result_q && prev_q |=> fall_q)
    else $error("falling edge did not set the fall flag");
  a_flags_sticky:
    assert property ((rise_q || fall_q) && !flag_wr_i |=> ($stable(rise_q) || rise_q) && ($stable(fall_q) || fall_q))
    else $error("edge flag cleared without a software write");
  a_irq_from_flags:
    assert property (irq_q == ((rise_q && $past(rise_ie_i)) || (fall_q && $past(fall_ie_i))))
    else $error("interrupt request does not match flags and enables");
  a_result_two_stage:
    assert property (en_i [*3] |-> result_q == $past(cmp_raw_i, 3))
    else $error("result does not follow the input after two sync stages");
  a_disabled_low:
    assert property (!en_i |=> !result_q)
    else $error("disabled channel result not low");

  c_rise_seen: cover property (rise_evt);
  c_fall_seen: cover property (fall_evt);
endmodule : acc_chan
`default_nettype wire

// ---- logic/acc_top.sv ----
/*
  Two-channel analog comparator control: special function registers,
  analog core drive, crossbar outputs and interrupt requests.
  Assumes a single-cycle register bus on clk_sys_i; comparator results
  arrive asynchronously from the analog cores.
*/
// Overview of operation
// - two channels, alike but for channel-zero positive hysteresis; channel zero also offers its result as a reset source
// - raw output follows the comparator with no clock, usable in stop mode
// - latched output on the system clock, either output may go to a pin
// - each channel takes two-bit plus and minus input selects
// - enable bit powers the comparator; clearing it cuts supply and drives pins low
// - a disabled channel holds its routed pin output low
// - read-only result bit is 1 when plus exceeds minus
// - every falling transition sets the fall flag
// - every rising transition sets the rise flag
// - edge flags stay set until software writes them clear
// - interrupts on rising, falling or both transitions
// - negative hysteresis codes: off, 5 mV, 10 mV, 20 mV
// - channel-zero positive hysteresis: off, 5 mV, 10 mV, 10 mV
// - response time chosen by software through the mode register
// - control layout: enable 7, result 6, rise 5, fall 4, hysteresis 3:2 and 1:0
// - mode register: rise interrupt enable bit 5, fall bit 4, reset 0x02
// - response mode field: 0 fastest to 3 slowest, reset value 2
`timescale 1ns/10ps
`default_nettype none
module acc_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // special function register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // analog comparator cores
  input wire logic cmp0_raw_i,
  input wire logic cmp1_raw_i,
  output acc_pkg::acc_ana_t chan0_ana_o,
  output acc_pkg::acc_ana_t chan1_ana_o,
  // crossbar outputs
  output logic chan0_raw_out_o,
  output logic chan1_raw_out_o,
  output logic chan0_latched_out_o,
  output logic chan1_latched_out_o,
  output logic chan0_reset_src_o,
  // interrupt requests
  output logic chan0_irq_o,
  output logic chan1_irq_o
);
  acc_pkg::acc_cfg_t cfg_q [0:1];
  acc_pkg::acc_cfg_t next_cfg [0:1];
  acc_pkg::acc_stat_t stat [0:1];
  acc_pkg::acc_ana_t ana_q [0:1];
  acc_pkg::acc_ana_t next_ana [0:1];
  logic [7:0] rdata_q;
  logic [7:0] next_rdata;
  logic [1:0] wr_cn;
  logic [1:0] wr_md;
  logic [1:0] wr_mx;
  logic cmp_raw [0:1];

  function automatic logic [7:0] pack_cn(input acc_pkg::acc_cfg_t c, input acc_pkg::acc_stat_t s);
    logic [7:0] v;
    v = acc_pkg::ACC_BYTE_RST;
    v[acc_pkg::ACC_CN_EN_BIT] = c.en;
    v[acc_pkg::ACC_CN_OUT_BIT] = s.result;
    v[acc_pkg::ACC_CN_RISE_BIT] = s.rise_flag;
    v[acc_pkg::ACC_CN_FALL_BIT] = s.fall_flag;
    v[acc_pkg::ACC_CN_HYP_LSB +: 2] = c.pos_hyst;
    v[acc_pkg::ACC_CN_HYN_LSB +: 2] = c.neg_hyst;
    return v;
  endfunction : pack_cn

  // unused bits read as zero
  function automatic logic [7:0] pack_md(input acc_pkg::acc_cfg_t c);
    logic [7:0] v;
    v = acc_pkg::ACC_BYTE_RST;
    v[acc_pkg::ACC_MD_RIE_BIT] = c.rise_ie;
    v[acc_pkg::ACC_MD_FIE_BIT] = c.fall_ie;
    v[acc_pkg::ACC_MD_MODE_LSB +: 2] = c.mode;
    return v;
  endfunction : pack_md

  function automatic logic [7:0] pack_mx(input acc_pkg::acc_cfg_t c);
    logic [7:0] v;
    v = acc_pkg::ACC_BYTE_RST;
    v[acc_pkg::ACC_MX_PLUS_LSB +: 2] = c.plus_sel;
    v[acc_pkg::ACC_MX_MINUS_LSB +: 2] = c.minus_sel;
    return v;
  endfunction : pack_mx

  assign cmp_raw[0] = cmp0_raw_i;
  assign cmp_raw[1] = cmp1_raw_i;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      wr_cn[i] = sfr_wr_i && (sfr_addr_i == acc_pkg::ACC_CN_ADDR[i]);
      wr_md[i] = sfr_wr_i && (sfr_addr_i == acc_pkg::ACC_MD_ADDR[i]);
      wr_mx[i] = sfr_wr_i && (sfr_addr_i == acc_pkg::ACC_MX_ADDR[i]);
    end
  end

  // configuration registers; flag bits live in the channel
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      next_cfg[i] = cfg_q[i];
      if (wr_cn[i])
      begin
        next_cfg[i].en = sfr_wdata_i[acc_pkg::ACC_CN_EN_BIT];
        next_cfg[i].pos_hyst = sfr_wdata_i[acc_pkg::ACC_CN_HYP_LSB +: 2];
        next_cfg[i].neg_hyst = sfr_wdata_i[acc_pkg::ACC_CN_HYN_LSB +: 2];
      end
      if (wr_md[i])
      begin
        next_cfg[i].rise_ie = sfr_wdata_i[acc_pkg::ACC_MD_RIE_BIT];
        next_cfg[i].fall_ie = sfr_wdata_i[acc_pkg::ACC_MD_FIE_BIT];
        next_cfg[i].mode = sfr_wdata_i[acc_pkg::ACC_MD_MODE_LSB +: 2];
      end
      if (wr_mx[i])
      begin
        next_cfg[i].plus_sel = sfr_wdata_i[acc_pkg::ACC_MX_PLUS_LSB +: 2];
        next_cfg[i].minus_sel = sfr_wdata_i[acc_pkg::ACC_MX_MINUS_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < 2; i++)
      begin
        cfg_q[i].en <= 1'b0;
        cfg_q[i].pos_hyst <= acc_pkg::ACC_FIELD2_RST;
        cfg_q[i].neg_hyst <= acc_pkg::ACC_FIELD2_RST;
        cfg_q[i].rise_ie <= 1'b0;
        cfg_q[i].fall_ie <= 1'b0;
        cfg_q[i].mode <= acc_pkg::ACC_MODE_RST;
        cfg_q[i].plus_sel <= acc_pkg::ACC_FIELD2_RST;
        cfg_q[i].minus_sel <= acc_pkg::ACC_FIELD2_RST;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        cfg_q[i] <= next_cfg[i];
      end
    end
  end

  // analog drive is registered so the cores see glitch-free controls
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      next_ana[i].power = cfg_q[i].en;
      next_ana[i].mode = cfg_q[i].mode;
      next_ana[i].plus_sel = cfg_q[i].plus_sel;
      next_ana[i].minus_sel = cfg_q[i].minus_sel;
      next_ana[i].pos_hyst = acc_pkg::acc_decode_hyst(cfg_q[i].pos_hyst, i != 0);
      next_ana[i].neg_hyst = acc_pkg::acc_decode_hyst(cfg_q[i].neg_hyst, 1'b1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < 2; i++)
      begin
        ana_q[i].power <= 1'b0;
        ana_q[i].mode <= acc_pkg::ACC_MODE_RST;
        ana_q[i].plus_sel <= acc_pkg::ACC_FIELD2_RST;
        ana_q[i].minus_sel <= acc_pkg::ACC_FIELD2_RST;
        ana_q[i].pos_hyst <= acc_pkg::ACC_HYST_OFF;
        ana_q[i].neg_hyst <= acc_pkg::ACC_HYST_OFF;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        ana_q[i] <= next_ana[i];
      end
    end
  end

  // read data is captured on the read strobe and held; unmapped reads give zero
  always_comb
  begin
    next_rdata = rdata_q;
    if (sfr_rd_i)
    begin
      next_rdata = acc_pkg::ACC_BYTE_RST;
      for (int i = 0; i < 2; i++)
      begin
        if (sfr_addr_i == acc_pkg::ACC_CN_ADDR[i])
          next_rdata = pack_cn(cfg_q[i], stat[i]);
        if (sfr_addr_i == acc_pkg::ACC_MD_ADDR[i])
          next_rdata = pack_md(cfg_q[i]);
        if (sfr_addr_i == acc_pkg::ACC_MX_ADDR[i])
          next_rdata = pack_mx(cfg_q[i]);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_q <= acc_pkg::ACC_BYTE_RST;
    else
      rdata_q <= next_rdata;
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_chan
    acc_chan u_chan (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .cmp_raw_i(cmp_raw[g]),
      .en_i(cfg_q[g].en),
      .rise_ie_i(cfg_q[g].rise_ie),
      .fall_ie_i(cfg_q[g].fall_ie),
      .flag_wr_i(wr_cn[g]),
      .rise_wdata_i(sfr_wdata_i[acc_pkg::ACC_CN_RISE_BIT]),
      .fall_wdata_i(sfr_wdata_i[acc_pkg::ACC_CN_FALL_BIT]),
      .stat_o(stat[g])
    );
  end

  assign sfr_rdata_o = rdata_q;
  assign chan0_ana_o = ana_q[0];
  assign chan1_ana_o = ana_q[1];
  // raw path must work with the clock stopped, so it bypasses the synchroniser and is gated only by the enable register bit
  assign chan0_raw_out_o = cmp0_raw_i & cfg_q[0].en;
  assign chan1_raw_out_o = cmp1_raw_i & cfg_q[1].en;
  assign chan0_latched_out_o = stat[0].result;
  assign chan1_latched_out_o = stat[1].result;
  assign chan0_reset_src_o = stat[0].result;
  assign chan0_irq_o = stat[0].irq;
  assign chan1_irq_o = stat[1].irq;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  a_mode_after_reset:
    assert property ($rose(rstn_i) |-> cfg_q[0].mode == 2'h2 && cfg_q[1].mode == 2'h2)
    else $error("response mode did not reset to mode 2");
  a_chan0_pos_cap:
    assert property (chan0_ana_o.pos_hyst != 4'h8)
    else $error("channel zero positive hysteresis reached 20 mV");
  a_neg_hyst_20mv:
    assert property (cfg_q[1].neg_hyst == 2'h3 |=> chan1_ana_o.neg_hyst == 4'h8)
    else $error("negative hysteresis code 3 did not select 20 mV");
  a_enable_powers:
    assert property (wr_cn[0] |=> ##1 chan0_ana_o.power == $past(sfr_wdata_i[7], 2))
    else $error("enable write did not reach the analog power control");
  a_raw_low_disabled:
    assert property (!cfg_q[1].en |-> !chan1_raw_out_o ##1 !chan1_latched_out_o)
    else $error("disabled channel drove its crossbar output");
  a_unmapped_zero:
    assert property (sfr_rd_i && (sfr_addr_i < acc_pkg::ACC_CN_ADDR[0]
      || sfr_addr_i > acc_pkg::ACC_MX_ADDR[1]) |=> sfr_rdata_o == acc_pkg::ACC_BYTE_RST)
    else $error("unmapped read did not return zero");
  a_mode_readback:
    assert property (wr_md[0] ##1 !wr_md[0] ##1 (sfr_rd_i && sfr_addr_i == acc_pkg::ACC_MD_ADDR[0])
      |=> sfr_rdata_o == ($past(sfr_wdata_i, 3) & 8'h33))
    else $error("mode register read back wrong value");
  a_status_bit_read:
    assert property (sfr_rd_i && sfr_addr_i == 8'h9A |=> sfr_rdata_o[6] == $past(stat[0].result))
    else $error("status bit read does not show the channel result");

  c_chan0_irq: cover property (chan0_irq_o);
  c_chan1_enabled: cover property (wr_cn[1] && sfr_wdata_i[7]);
  c_both_flags: cover property (stat[0].rise_flag && stat[0].fall_flag);
endmodule : acc_top
`default_nettype wire

// ---- test/acc_core_model.sv ----
/*
  Behavioural model of one analog comparator core as seen by the control block.
  Assumes the bench sets level_i to the wanted comparison result.
*/
`timescale 1ns/10ps
`default_nettype none
module acc_core_model (
  // clock
  input wire logic clk_sys_i,
  // analog control and stimulus
  input wire logic power_i,
  input wire logic level_i,
  // comparator result
  output logic raw_o
);
  logic junk = 1'b0;

  always_ff @(posedge clk_sys_i)
  begin
    junk <= ~junk;
  end

  // an unpowered core has no valid result, so a toggling value keeps stale levels from passing
  assign raw_o = power_i ? level_i : junk;
endmodule : acc_core_model
`default_nettype wire

// ---- test/analog_comparator_control_test.sv ----
/*
  Self-checking bench for the two-channel comparator control block.
  Assumes the single-cycle register bus of the block; read data is
  checked one edge after the read is taken, from a queue of expectations.
*/
`timescale 1ns/10ps
`default_nettype none
module analog_comparator_control_test;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  wire logic [7:0] sfr_rdata_o;
  wire logic cmp0_raw, cmp1_raw, raw0, raw1, lat0, lat1, reset_src, irq0, irq1;
  wire acc_pkg::acc_ana_t ana0, ana1;
  logic [1:0] level = 2'h0;
  logic [7:0] exp_q [$];
  logic rd_seen = 1'b0;
  int failures = 0;
  int n_compared = 0;
  logic [15:0] rng = 16'hFE24;

  always #20 clk_sys_i = ~clk_sys_i;

  acc_top acc_top_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .cmp0_raw_i(cmp0_raw), .cmp1_raw_i(cmp1_raw),
    .chan0_ana_o(ana0), .chan1_ana_o(ana1), .chan0_raw_out_o(raw0), .chan1_raw_out_o(raw1),
    .chan0_latched_out_o(lat0), .chan1_latched_out_o(lat1), .chan0_reset_src_o(reset_src),
    .chan0_irq_o(irq0), .chan1_irq_o(irq1));
  acc_core_model core0_i (.clk_sys_i(clk_sys_i), .power_i(ana0.power), .level_i(level[0]),
    .raw_o(cmp0_raw));
  acc_core_model core1_i (.clk_sys_i(clk_sys_i), .power_i(ana1.power), .level_i(level[1]),
    .raw_o(cmp1_raw));

  function automatic logic [15:0] xs(input logic [15:0] v);
    logic [15:0] t;
    t = v ^ (v << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction : xs

  function automatic acc_pkg::acc_ana_t ana_of(input int ch);
    return (ch != 0) ? ana1 : ana0;
  endfunction : ana_of

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    sfr_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge clk_sys_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    sfr_rd_i <= 1'b0;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : settle

  // read data is loaded at the taking edge, so it is judged at the following edge
  always @(posedge clk_sys_i)
  begin
    if (rd_seen)
    begin
      if (exp_q.size() == 0)
        chk("read queue", 8'h00, 8'h01);
      else
        chk("read data", sfr_rdata_o, exp_q.pop_front());
    end
    rd_seen <= sfr_rd_i;
  end

  task automatic close_out();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    failures++;
    close_out();
  end

  initial
  begin
    logic [7:0] cn, md, mx, r;
    logic [3:0] ph;
    repeat (16) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      rd(acc_pkg::ACC_CN_ADDR[i], 8'h00);
      rd(acc_pkg::ACC_MD_ADDR[i], 8'h02);
      rd(acc_pkg::ACC_MX_ADDR[i], 8'h00);
      chk("mode after reset", 8'(ana_of(i).mode), 8'h02);
      chk("neg hyst after reset", 8'(ana_of(i).neg_hyst), 8'h01);
    end
    rd(8'hA0, 8'h00);
    for (int ch = 0; ch < 2; ch++)
    begin
      cn = acc_pkg::ACC_CN_ADDR[ch];
      md = acc_pkg::ACC_MD_ADDR[ch];
      mx = acc_pkg::ACC_MX_ADDR[ch];
      for (int k = 0; k < 4; k++)
      begin
        rng = xs(rng);
        r = rng[7:0];
        wr(md, r);
        rd(md, r & 8'h33);
        chk("response mode", 8'(ana_of(ch).mode), 8'(r[1:0]));
        rng = xs(rng);
        r = rng[7:0];
        wr(mx, r);
        wr(8'hA0, ~r);
        rd(mx, r & 8'h33);
        chk("plus select", 8'(ana_of(ch).plus_sel), 8'(r[1:0]));
        chk("minus select", 8'(ana_of(ch).minus_sel), 8'(r[5:4]));
        rd(8'hA0, 8'h00);
      end
      for (int c = 0; c < 4; c++)
      begin
        wr(cn, 8'((c << 2) | c));
        settle(1);
        ph = (ch == 0 && c == 3) ? 4'h4 : 4'(4'h1 << c);
        chk("pos hyst", 8'(ana_of(ch).pos_hyst), 8'(ph));
        chk("neg hyst", 8'(ana_of(ch).neg_hyst), 8'(4'h1 << c));
        rd(cn, 8'((c << 2) | c));
      end
      wr(md, 8'h20);
      wr(cn, 8'h80);
      settle(6);
      chk("power on", 8'(ana_of(ch).power), 8'h01);
      wr(cn, 8'h80);
      rd(cn, 8'h80);
      @(posedge clk_sys_i);
      level[ch] <= 1'b1;
      #1;
      chk("raw out", 8'((ch != 0) ? raw1 : raw0), 8'h01);
      settle(2);
      chk("latched early", 8'((ch != 0) ? lat1 : lat0), 8'h00);
      settle(1);
      chk("latched out", 8'((ch != 0) ? lat1 : lat0), 8'h01);
      if (ch == 0)
        chk("reset source", 8'(reset_src), 8'h01);
      settle(1);
      chk("irq rise", 8'((ch != 0) ? irq1 : irq0), 8'h01);
      rd(cn, 8'hE0);
      @(posedge clk_sys_i);
      level[ch] <= 1'b0;
      settle(5);
      rd(cn, 8'hB0);
      wr(cn, 8'h90);
      settle(2);
      chk("irq masked fall", 8'((ch != 0) ? irq1 : irq0), 8'h00);
      wr(md, 8'h10);
      settle(2);
      chk("irq fall", 8'((ch != 0) ? irq1 : irq0), 8'h01);
      wr(cn, 8'h80);
      settle(2);
      chk("irq cleared", 8'((ch != 0) ? irq1 : irq0), 8'h00);
      wr(cn, 8'h00);
      @(posedge clk_sys_i);
      level[ch] <= 1'b1;
      for (int n = 0; n < 6; n++)
      begin
        settle(1);
        chk("raw off", 8'((ch != 0) ? raw1 : raw0), 8'h00);
        chk("latched off", 8'((ch != 0) ? lat1 : lat0), 8'h00);
      end
      chk("power off", 8'(ana_of(ch).power), 8'h00);
      rd(cn, 8'h00);
      @(posedge clk_sys_i);
      level[ch] <= 1'b0;
    end
    settle(4);
    close_out();
  end
endmodule : analog_comparator_control_test
`default_nettype wire
